// *** boot_gate_asserts.sv ***
// concurrent checks on the link between boot gate device and host
module boot_gate_asserts
    import boot_gate_pkg::*;
#(
    parameter int COPY_CYC = COPY_CYC_DEFAULT
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // link signals
    input wire logic reset_input_n,
    input wire logic busy_n,
    input wire logic rd_req,
    input wire logic rdata_valid,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic download_running_bit
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    // busy cycles since reset release; a counter, since the copy is too long to unroll
    int wait_reg;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wait_reg <= 0;
        end else if (!reset_input_n) begin
            wait_reg <= 0;
        end else if (!busy_n) begin
            wait_reg <= wait_reg + 1;
        end
    end

    // ----------------------------------------
    // assertions and covers
    // ----------------------------------------
    a_busy_on_reset: assert property ($fell(reset_input_n) |=> !busy_n)
        else $error("busy not asserted after reset fell");
    a_reset_state: assert property (!reset_input_n |=> !busy_n && download_running_bit)
        else $error("device not held in reset state");
    a_release_pair: assert property (busy_n != download_running_bit)
        else $error("busy and download bit disagree");
    a_release_limit: assert property (wait_reg <= COPY_CYC + ERASE_EXTRA_CYC + 2)
        else $error("busy held past its limit");
    a_no_early_release: assert property ($rose(busy_n) |-> wait_reg >= COPY_CYC)
        else $error("busy released before copy finished");
    a_quiet_in_copy: assert property (!busy_n |-> !rdata_valid)
        else $error("read answered during copy");
    a_first_read: assert property ($rose(busy_n) && rd_req |-> rdata_valid)
        else $error("pending read not valid at busy release");
    a_valid_pulse: assert property (rdata_valid |=> !rdata_valid)
        else $error("read valid longer than one cycle");
    a_rdata_hold: assert property (busy_n && $changed(rdata) |-> rdata_valid)
        else $error("read data changed without a read");
    c_first_read: cover property ($rose(busy_n) && rd_req);
    c_reset: cover property ($fell(reset_input_n));
    c_long_boot: cover property ($rose(busy_n) && wait_reg > COPY_CYC + 8);
endmodule

// *** boot_gate_bench.sv ***
// self-checking bench joining the device end and the host end
module boot_gate_bench
    import boot_gate_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // short copy keeps the run small
    localparam int COPY_SIM = 16;
    localparam int TIME_LIMIT = 90000;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic erase_active = 1'b0;
    logic power_down_req = 1'b0;
    logic start = 1'b0;
    logic wake_toggle = 1'b0;
    logic [ADDR_W-1:0] first_addr = 16'h0000;
    logic [BOOT_AW-1:0] flash_addr;
    logic [DATA_W-1:0] flash_data;
    logic [DATA_W-1:0] first_data;
    logic done;
    logic powered_down;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    int wait_cyc = 0;

    // ----------------------------------------
    // ends, link and checker
    // ----------------------------------------
    boot_gate_if link ();
    boot_gate_device #(.COPY_CYC(COPY_SIM)) boot_gate_device_inst (.CLK(clk), .RESET_N(reset_n), .LINK(link),
        .ERASE_ACTIVE(erase_active), .FLASH_DATA(flash_data), .FLASH_ADDR(flash_addr),
        .POWERED_DOWN(powered_down), .POWER_DOWN_REQ(power_down_req));
    boot_gate_host boot_gate_host_inst (.CLK(clk), .RESET_N(reset_n), .LINK(link), .START(start),
        .FIRST_ADDR(first_addr), .WAKE_TOGGLE(wake_toggle), .FIRST_DATA(first_data), .DONE(done));
    boot_gate_asserts #(.COPY_CYC(COPY_SIM)) boot_gate_asserts_inst (.CLK(clk), .RESET_N(reset_n),
        .reset_input_n(link.reset_input_n), .busy_n(link.busy_n), .rd_req(link.rd_req),
        .rdata_valid(link.rdata_valid), .rdata(link.rdata), .download_running_bit(link.download_running_bit));

    // flash source: word pattern tied to its address, answered in the same cycle
    function automatic logic [DATA_W-1:0] flash_word(input logic [ADDR_W-1:0] a);
        return {6'h00, a[BOOT_AW-1:0]} ^ 16'h5a00;
    endfunction
    assign flash_data = flash_word({6'h00, flash_addr});

    // ----------------------------------------
    // clock, timeout, report
    // ----------------------------------------
    initial begin
        forever #4 clk = ~clk;
    end
    // long enough for one erase-stretched boot plus the short ones
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == TIME_LIMIT) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    // reset through the host end, then its busy-stretched first read; counts busy cycles after release
    task automatic boot_read(input logic [ADDR_W-1:0] a, input logic erase);
        int guard;
        logic seen_busy;
        guard = 0;
        seen_busy = 1'b0;
        wait_cyc = 0;
        @(negedge clk);
        first_addr = a;
        erase_active = erase;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        while (!(seen_busy && done === 1'b1) && guard < 70000) begin
            @(negedge clk);
            guard++;
            seen_busy = seen_busy | (link.busy_n === 1'b0);
            if (link.reset_input_n === 1'b1 && link.busy_n === 1'b0) begin
                wait_cyc++;
            end
        end
        erase_active = 1'b0;
    endtask
    // data, copy length and status after one boot
    task automatic verify(input logic [ADDR_W-1:0] a, input int extra);
        check("first_data", first_data, flash_word(a));
        check("copy_len", 16'(wait_cyc), 16'(COPY_SIM + 1 + extra));
        check("busy_n", 16'(link.busy_n), 16'h0001);
        check("download_running_bit", 16'(link.download_running_bit), DATA_ZERO);
        check("within_max_wait", 16'(wait_cyc <= BUSY_RELEASE_MAX_CYC), 16'h0001);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        boot_read(16'h0004, 1'b0);
        verify(16'h0004, 0);
        boot_read(16'h000a, 1'b0);
        verify(16'h000a, 0);
        boot_read(16'h0006, 1'b1);
        verify(16'h0006, ERASE_EXTRA_CYC);
        // power down, then wake by toggling the lowest address line
        @(negedge clk);
        power_down_req = 1'b1;
        repeat (4) @(negedge clk);
        power_down_req = 1'b0;
        check("powered_down", 16'(powered_down), 16'h0001);
        wake_toggle = 1'b1;
        @(negedge clk);
        wake_toggle = 1'b0;
        check("a0_toggle", 16'(link.deep_power_down_exit_control), 16'h0001);
        repeat (WAKE_DATA_VALID_CYC - 8) @(negedge clk);
        check("still_down", 16'(powered_down), 16'h0001);
        repeat (16) @(negedge clk);
        check("awake", 16'(powered_down), DATA_ZERO);
        end_of_test();
    end
endmodule

// *** boot_gate_device.sv ***
// device end: reset, boot download and access gating
//
// Behaviour
// - reset input low forces reset state
// - reset release starts boot code copy
// - host accesses ignored during copy
// - busy released within ten ms
// - delay-waiting host waits maximum busy time
// - erase at reset adds 500 us
// - host may poll busy instead
// - download bit one while copying, polled
// - busy stretches first read, data valid
// - read data valid by busy release
// - booting host uses busy wait states
// - host holds reset at least 50 ns
// - busy asserted within 50 ns
// - address bit zero toggle exits power-down
// - read data 700 ns after exit
module boot_gate_device
    import boot_gate_pkg::*;
#(
    parameter int COPY_CYC = COPY_CYC_DEFAULT
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // link
    boot_gate_if.device LINK,
    // user side: flash source and status
    input wire logic ERASE_ACTIVE,
    input wire logic [DATA_W-1:0] FLASH_DATA,
    output logic [BOOT_AW-1:0] FLASH_ADDR,
    output logic POWERED_DOWN,
    input wire logic POWER_DOWN_REQ
);
    typedef enum logic [1:0] {ST_RESET, ST_COPY, ST_READY, ST_SLEEP} dev_state_t;

    typedef struct packed {
        dev_state_t state;
        // copy progress, its length and the boot block write pointer
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] limit;
        logic [BOOT_AW-1:0] waddr;
        // link outputs, each a flop
        logic busy_n;
        logic copying;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        // first read held while the copy runs
        logic pending_rd;
        logic [ADDR_W-1:0] pend_addr;
        // power-down and wake timing
        logic a0_last;
        logic [CNT_W-1:0] wake_cnt;
        logic toggled;
        logic asleep;
        // erase seen during reset lengthens the next copy
        logic erase_seen;
    } dev_t;

    logic [DATA_W-1:0] boot_mem [BOOT_WORDS];
    dev_t s_reg, s_next;
    logic mem_we;

    localparam logic [CNT_W-1:0] COPY_LEN = CNT_W'(COPY_CYC);
    localparam logic [CNT_W-1:0] EXTRA_LEN = CNT_W'(ERASE_EXTRA_CYC);
    localparam logic [CNT_W-1:0] WAKE_LEN = CNT_W'(WAKE_DATA_VALID_CYC);

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // boot block index: only the low address bits select a word, the
    // upper bits alias so a host never reads outside the block
    function automatic logic [BOOT_AW-1:0] boot_index(input logic [ADDR_W-1:0] a);
        return a[BOOT_AW-1:0];
    endfunction

    // a count of len edges is done when the register holds len - 1;
    // comparing at or above keeps a stray overshoot from hanging the state
    function automatic logic count_done(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] len);
        return cnt >= len - CNT_ONE;
    endfunction

    // a read is taken once per request: the cycle after an answer the
    // host is still dropping its level request, so that cycle is skipped
    function automatic logic read_taken(input logic req, input logic answered);
        return req && !answered;
    endfunction

    // -----------------------------------------------------------------
    // next-state logic
    // -----------------------------------------------------------------
    // reset input low holds state, counters, pending read and sleep in reset, busy low next edge
    always_comb begin
        s_next = s_reg;
        s_next.rvalid = 1'b0;
        mem_we = 1'b0;
        if (!LINK.reset_input_n) begin
            s_next.state = ST_RESET;
            s_next.busy_n = 1'b0; // one edge, well inside 50 ns
            s_next.copying = 1'b1;
            s_next.pending_rd = 1'b0;
            s_next.cnt = CNT_ZERO;
            s_next.waddr = '0;
            // a reset also cancels power-down and any half-seen wake toggle
            s_next.asleep = 1'b0;
            s_next.toggled = 1'b0;
            s_next.wake_cnt = CNT_ZERO;
            // latched erase lengthens the coming copy
            if (ERASE_ACTIVE) begin
                s_next.erase_seen = 1'b1;
            end
        end else begin
            unique case (s_reg.state)
                ST_RESET: begin
                    s_next.state = ST_COPY;
                    s_next.limit = s_reg.erase_seen ? COPY_LEN + EXTRA_LEN : COPY_LEN;
                    s_next.erase_seen = 1'b0;
                end
                ST_COPY: begin
                    mem_we = 1'b1;
                    s_next.waddr = s_reg.waddr + 1'b1;
                    s_next.cnt = s_reg.cnt + CNT_ONE;
                    // the first read is held, not answered; writes dropped
                    if (LINK.rd_req && !s_reg.pending_rd) begin
                        s_next.pending_rd = 1'b1;
                        s_next.pend_addr = LINK.addr;
                    end
                    // a write is never decoded: the boot block is filled by the copy alone
                    if (count_done(s_reg.cnt, s_reg.limit)) begin
                        // busy rises and status drops in the same edge
                        s_next.state = ST_READY;
                        s_next.busy_n = 1'b1;
                        s_next.copying = 1'b0;
                        if (s_reg.pending_rd) begin
                            // data valid no later than the busy edge
                            s_next.rdata = boot_mem[boot_index(s_reg.pend_addr)];
                            s_next.rvalid = 1'b1;
                        end
                        // a request not yet latched is served from the ready state instead
                        s_next.pending_rd = 1'b0;
                    end
                end
                ST_READY: begin
                    // back to back requests are answered every other cycle
                    if (read_taken(LINK.rd_req, s_reg.rvalid)) begin
                        s_next.rdata = boot_mem[boot_index(LINK.addr)];
                        s_next.rvalid = 1'b1;
                    end
                    if (POWER_DOWN_REQ) begin
                        s_next.state = ST_SLEEP;
                        s_next.asleep = 1'b1;
                        s_next.toggled = 1'b0;
                        s_next.a0_last = LINK.deep_power_down_exit_control;
                        s_next.wake_cnt = CNT_ZERO;
                    end
                end
                ST_SLEEP: begin
                    // reads are refused until the wake time has run out
                    if (!s_reg.toggled) begin
                        // a toggle on address bit zero starts the wake timer
                        if (LINK.deep_power_down_exit_control != s_reg.a0_last) begin
                            s_next.toggled = 1'b1;
                        end
                    end else if (count_done(s_reg.wake_cnt, WAKE_LEN)) begin
                        // powered-down flag holds until data can be served
                        s_next.state = ST_READY;
                        s_next.asleep = 1'b0;
                    end else begin
                        s_next.wake_cnt = s_reg.wake_cnt + CNT_ONE;
                    end
                end
                default: s_next.state = ST_RESET;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // state register and boot block
    // -----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_reg <= '{state: ST_RESET, cnt: CNT_ZERO, limit: CNT_ZERO, waddr: '0, busy_n: 1'b0,
                       copying: 1'b1, rdata: DATA_ZERO, rvalid: 1'b0, pending_rd: 1'b0,
                       pend_addr: '0, a0_last: 1'b0, wake_cnt: CNT_ZERO, toggled: 1'b0,
                       asleep: 1'b0, erase_seen: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    // boot block has no reset: contents come from the copy
    always_ff @(posedge CLK) begin
        if (mem_we) begin
            boot_mem[s_reg.waddr] <= FLASH_DATA;
        end
    end

    // -----------------------------------------------------------------
    // outputs straight from flops
    // -----------------------------------------------------------------
    assign LINK.busy_n = s_reg.busy_n;
    assign LINK.download_running_bit = s_reg.copying;
    assign LINK.rdata = s_reg.rdata;
    assign LINK.rdata_valid = s_reg.rvalid;
    assign FLASH_ADDR = s_reg.waddr;
    // stays high through the wake time, so a user never reads too early
    assign POWERED_DOWN = s_reg.asleep;
endmodule

// *** boot_gate_host.sv ***
// host end: drives reset, waits on busy, makes first read
module boot_gate_host
    import boot_gate_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // link
    boot_gate_if.host LINK,
    // user side
    input wire logic START,
    input wire logic [ADDR_W-1:0] FIRST_ADDR,
    input wire logic WAKE_TOGGLE,
    output logic [DATA_W-1:0] FIRST_DATA,
    output logic DONE
);
    typedef enum logic [1:0] {H_IDLE, H_RESET, H_WAIT, H_DONE} host_state_t;

    typedef struct packed {
        host_state_t state;
        logic [CNT_W-1:0] cnt;
        logic rst_n;
        logic rd;
        logic a0;
        logic [DATA_W-1:0] data;
        logic done;
    } host_reg_t;

    localparam logic [CNT_W-1:0] RST_LEN = CNT_W'(RESET_MIN_CYC);
    host_reg_t h_reg, h_next;

    // -----------------------------------------------------------------
    // sequence: pulse reset, hold first read until busy lets go
    // -----------------------------------------------------------------
    always_comb begin
        h_next = h_reg;
        if (WAKE_TOGGLE) begin
            h_next.a0 = ~h_reg.a0;
        end
        unique case (h_reg.state)
            // a start after done reboots at once, with no idle step to miss
            H_IDLE, H_DONE: begin
                if (START) begin
                    h_next.state = H_RESET;
                    h_next.rst_n = 1'b0;
                    h_next.cnt = CNT_ZERO;
                    h_next.done = 1'b0;
                end
            end
            H_RESET: begin
                // hold at least the minimum reset width
                if (h_reg.cnt >= RST_LEN) begin
                    h_next.rst_n = 1'b1;
                    h_next.rd = 1'b1; // first read stretched by busy
                    h_next.state = H_WAIT;
                end else begin
                    h_next.cnt = h_reg.cnt + CNT_ONE;
                end
            end
            H_WAIT: begin
                // the read stands until the device answers after busy
                if (LINK.rdata_valid && LINK.busy_n) begin
                    h_next.rd = 1'b0;
                    h_next.data = LINK.rdata;
                    h_next.done = 1'b1;
                    h_next.state = H_DONE;
                end
            end
            default: h_next.state = H_IDLE;
        endcase
    end

    // -----------------------------------------------------------------
    // register
    // -----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            h_reg <= '{state: H_IDLE, cnt: CNT_ZERO, rst_n: 1'b1, rd: 1'b0, a0: 1'b0,
                       data: DATA_ZERO, done: 1'b0};
        end else begin
            h_reg <= h_next;
        end
    end

    // outputs from flops, except the upper address bits, which come straight from FIRST_ADDR, and the write request and data, which are tied off
    assign LINK.reset_input_n = h_reg.rst_n;
    assign LINK.rd_req = h_reg.rd;
    assign LINK.wr_req = 1'b0;
    assign LINK.addr = {FIRST_ADDR[ADDR_W-1:1], h_reg.a0};
    assign LINK.wdata = DATA_ZERO;
    assign LINK.deep_power_down_exit_control = h_reg.a0;
    assign FIRST_DATA = h_reg.data;
    assign DONE = h_reg.done;
endmodule

// *** boot_gate_if.sv ***
// link between the boot gate device end and its host end
interface boot_gate_if;
    import boot_gate_pkg::*;
    logic reset_input_n;
    logic busy_n;
    logic rd_req;
    logic wr_req;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rdata_valid;
    logic download_running_bit;
    logic deep_power_down_exit_control;

    modport device (
        input reset_input_n, rd_req, wr_req, addr, wdata, deep_power_down_exit_control,
        output busy_n, rdata, rdata_valid, download_running_bit
    );
    modport host (
        output reset_input_n, rd_req, wr_req, addr, wdata, deep_power_down_exit_control,
        input busy_n, rdata, rdata_valid, download_running_bit
    );
endinterface

// *** boot_gate_pkg.sv ***
// shared constants for the reset / boot download gate
package boot_gate_pkg;
    // clock rate
    localparam int CLK_PERIOD_NS = 8;
    localparam int CLK_MHZ = 125;

    // timing figures in their own units
    localparam int BUSY_RELEASE_MAX_MS = 10;
    localparam int ERASE_EXTRA_US = 500;
    localparam int RESET_MIN_NS = 50;
    localparam int BUSY_ASSERT_MAX_NS = 50;
    localparam int WAKE_DATA_VALID_NS = 700;

    // derived cycle counts (least times round up, longest round down)
    localparam int BUSY_RELEASE_MAX_CYC = BUSY_RELEASE_MAX_MS * 1000 * CLK_MHZ;
    localparam int ERASE_EXTRA_CYC = ERASE_EXTRA_US * CLK_MHZ;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_ASSERT_MAX_CYC = BUSY_ASSERT_MAX_NS / CLK_PERIOD_NS;
    localparam int WAKE_DATA_VALID_CYC = (WAKE_DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // widths
    localparam int CNT_W = 21;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BOOT_WORDS = 1024;
    localparam int BOOT_AW = 10;

    // default copy length: shorter than the busy limit
    localparam int COPY_CYC_DEFAULT = 1024;

    // counter constants at counter width, data zero at data width
    localparam logic [CNT_W-1:0] CNT_ZERO = 21'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 21'h1;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
endpackage
